// >>> drb_loop_div_regs.v
// AXI4-Lite register slice: loop bandwidth, filter select and feedback divider
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "drb_regs_map.vh"

module drb_loop_div_regs #(
   parameter ADDR_W = 16
) (
   input wire aclk,
   input wire aresetn,
   input wire [ADDR_W-1:0] s_axi_awaddr,
   input wire [2:0] s_axi_awprot,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [ADDR_W-1:0] s_axi_araddr,
   input wire [2:0] s_axi_arprot,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   output reg [15:0] loop_bw_scale_r,
   output reg high_margin_filter_r,
   output reg [16:0] integer_divider_field_r,
   output reg [17:0] feedback_divide_value_r,
   output reg [22:0] fraction_numerator_r,
   output reg [22:0] fraction_modulus_r
);

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   // Returns slot 0..11, or 12 when the byte address hits no register
   function [3:0] slot_of;
      input [ADDR_W-1:0] addr;
      reg [ADDR_W-1:0] idx;
      reg [ADDR_W-1:0] diff;
      begin
         idx = addr >> 2;
         diff = idx - `DRB_IDX_FIRST;
         if (addr[1:0] != 2'b00 || idx < `DRB_IDX_FIRST
            || idx > `DRB_IDX_MOD_HI) begin
            slot_of = `DRB_NUM_REGS;
         end else begin
            slot_of = diff[3:0];
         end
      end
   endfunction

   // ----------------------------------------------------------------
   // Write channel
   // ----------------------------------------------------------------
   reg aw_held_r;
   reg w_held_r;
   reg [ADDR_W-1:0] aw_addr_r;
   reg [7:0] w_byte_r;
   reg w_lane0_r;

   wire aw_take = s_axi_awvalid && s_axi_awready;
   wire w_take = s_axi_wvalid && s_axi_wready;
   wire wr_go = aw_held_r && w_held_r && !s_axi_bvalid;
   wire [3:0] wr_slot = slot_of(aw_addr_r);
   wire wr_hit = wr_slot != `DRB_NUM_REGS;
   // Only byte lane 0 carries data; other lanes read zero
   wire wr_do = wr_go && wr_hit && w_lane0_r;

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         aw_addr_r <= {ADDR_W{1'b0}};
         w_byte_r <= 8'h00;
         w_lane0_r <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `DRB_RESP_OKAY;
      end else begin
         s_axi_awready <= !aw_held_r && !aw_take;
         s_axi_wready <= !w_held_r && !w_take;
         if (aw_take) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         if (w_take) begin
            w_held_r <= 1'b1;
            w_byte_r <= s_axi_wdata[7:0];
            w_lane0_r <= s_axi_wstrb[0];
         end
         if (wr_go) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `DRB_RESP_OKAY : `DRB_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Register storage
   // ----------------------------------------------------------------
   wire [7:0] bw_lo, bw_hi, filt, int_lo, int_mid, int_top;
   wire [7:0] num_lo, num_mid, num_hi, mod_lo, mod_mid, mod_hi;

   drb_reg_byte #(.RESET_VAL(`DRB_RST_BW_LO), .WR_MASK(`DRB_MASK_FULL)) u_bw_lo (
      .aclk(aclk), .aresetn(aresetn), .wr_en(wr_do && wr_slot == 4'h0),
      .wr_data(w_byte_r), .value_r(bw_lo));
   drb_reg_byte #(.RESET_VAL(`DRB_RST_BW_HI), .WR_MASK(`DRB_MASK_FULL)) u_bw_hi (
      .aclk(aclk), .aresetn(aresetn), .wr_en(wr_do && wr_slot == 4'h1),
      .wr_data(w_byte_r), .value_r(bw_hi));
   drb_reg_byte #(.RESET_VAL(`DRB_RST_FILT), .WR_MASK(`DRB_MASK_FILT)) u_filt (
      .aclk(aclk), .aresetn(aresetn), .wr_en(wr_do && wr_slot == 4'h2),
      .wr_data(w_byte_r), .value_r(filt));
   drb_reg_byte #(.RESET_VAL(`DRB_RST_INT_LO), .WR_MASK(`DRB_MASK_FULL)) u_int_lo (
      .aclk(aclk), .aresetn(aresetn), .wr_en(wr_do && wr_slot == 4'h3),
      .wr_data(w_byte_r), .value_r(int_lo));
   drb_reg_byte #(.RESET_VAL(`DRB_RST_INT_MID), .WR_MASK(`DRB_MASK_FULL)) u_int_mid (
      .aclk(aclk), .aresetn(aresetn), .wr_en(wr_do && wr_slot == 4'h4),
      .wr_data(w_byte_r), .value_r(int_mid));
   drb_reg_byte #(.RESET_VAL(`DRB_RST_INT_TOP), .WR_MASK(`DRB_MASK_INT_TOP)) u_int_top (
      .aclk(aclk), .aresetn(aresetn), .wr_en(wr_do && wr_slot == 4'h5),
      .wr_data(w_byte_r), .value_r(int_top));
   drb_reg_byte #(.RESET_VAL(`DRB_RST_NUM_LO), .WR_MASK(`DRB_MASK_FULL)) u_num_lo (
      .aclk(aclk), .aresetn(aresetn), .wr_en(wr_do && wr_slot == 4'h6),
      .wr_data(w_byte_r), .value_r(num_lo));
   drb_reg_byte #(.RESET_VAL(`DRB_RST_NUM_MID), .WR_MASK(`DRB_MASK_FULL)) u_num_mid (
      .aclk(aclk), .aresetn(aresetn), .wr_en(wr_do && wr_slot == 4'h7),
      .wr_data(w_byte_r), .value_r(num_mid));
   drb_reg_byte #(.RESET_VAL(`DRB_RST_NUM_HI), .WR_MASK(`DRB_MASK_HI7)) u_num_hi (
      .aclk(aclk), .aresetn(aresetn), .wr_en(wr_do && wr_slot == 4'h8),
      .wr_data(w_byte_r), .value_r(num_hi));
   drb_reg_byte #(.RESET_VAL(`DRB_RST_MOD_LO), .WR_MASK(`DRB_MASK_FULL)) u_mod_lo (
      .aclk(aclk), .aresetn(aresetn), .wr_en(wr_do && wr_slot == 4'h9),
      .wr_data(w_byte_r), .value_r(mod_lo));
   drb_reg_byte #(.RESET_VAL(`DRB_RST_MOD_MID), .WR_MASK(`DRB_MASK_FULL)) u_mod_mid (
      .aclk(aclk), .aresetn(aresetn), .wr_en(wr_do && wr_slot == 4'ha),
      .wr_data(w_byte_r), .value_r(mod_mid));
   drb_reg_byte #(.RESET_VAL(`DRB_RST_MOD_HI), .WR_MASK(`DRB_MASK_HI7)) u_mod_hi (
      .aclk(aclk), .aresetn(aresetn), .wr_en(wr_do && wr_slot == 4'hb),
      .wr_data(w_byte_r), .value_r(mod_hi));

   // ----------------------------------------------------------------
   // Assembled fields for the loop datapath
   // ----------------------------------------------------------------
   wire [16:0] int_field = {int_top[0], int_mid, int_lo};

   // Reset images of the assembled fields, built from the byte reset values
   // so the loop sees the documented defaults while reset is still held
   localparam [7:0] RST_FILT_BYTE = `DRB_RST_FILT;
   localparam [23:0] RST_INT_BYTES = {`DRB_RST_INT_TOP, `DRB_RST_INT_MID, `DRB_RST_INT_LO};
   localparam [16:0] RST_INT_FIELD = RST_INT_BYTES[16:0];
   localparam [17:0] RST_DIV_VALUE = {1'b0, RST_INT_FIELD} + 18'h00001;
   localparam [23:0] RST_NUM_BYTES = {`DRB_RST_NUM_HI, `DRB_RST_NUM_MID, `DRB_RST_NUM_LO};
   localparam [23:0] RST_MOD_BYTES = {`DRB_RST_MOD_HI, `DRB_RST_MOD_MID, `DRB_RST_MOD_LO};

   // Registered one cycle after the byte registers so all outputs are flops;
   // software writing bytes one at a time still sees torn values meanwhile
   always @(posedge aclk) begin
      if (!aresetn) begin
         loop_bw_scale_r <= {`DRB_RST_BW_HI, `DRB_RST_BW_LO};
         high_margin_filter_r <= RST_FILT_BYTE[`DRB_FILT_BIT];
         integer_divider_field_r <= RST_INT_FIELD;
         feedback_divide_value_r <= RST_DIV_VALUE;
         fraction_numerator_r <= RST_NUM_BYTES[22:0];
         fraction_modulus_r <= RST_MOD_BYTES[22:0];
      end else begin
         loop_bw_scale_r <= {bw_hi, bw_lo};
         high_margin_filter_r <= filt[`DRB_FILT_BIT];
         integer_divider_field_r <= int_field;
         feedback_divide_value_r <= {1'b0, int_field} + 18'h00001;
         fraction_numerator_r <= {num_hi[6:0], num_mid, num_lo};
         fraction_modulus_r <= {mod_hi[6:0], mod_mid, mod_lo};
      end
   end

   // ----------------------------------------------------------------
   // Read channel
   // ----------------------------------------------------------------
   reg [7:0] rd_byte;
   wire [3:0] rd_slot = slot_of(s_axi_araddr);
   wire ar_take = s_axi_arvalid && s_axi_arready;

   always @* begin
      case (rd_slot)
         4'h0: rd_byte = bw_lo;
         4'h1: rd_byte = bw_hi;
         4'h2: rd_byte = filt;
         4'h3: rd_byte = int_lo;
         4'h4: rd_byte = int_mid;
         4'h5: rd_byte = int_top;
         4'h6: rd_byte = num_lo;
         4'h7: rd_byte = num_mid;
         4'h8: rd_byte = num_hi;
         4'h9: rd_byte = mod_lo;
         4'ha: rd_byte = mod_mid;
         4'hb: rd_byte = mod_hi;
         default: rd_byte = 8'h00;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `DRB_RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !ar_take;
         if (ar_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_byte};
            s_axi_rresp <= (rd_slot == `DRB_NUM_REGS) ? `DRB_RESP_SLVERR : `DRB_RESP_OKAY;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

endmodule // drb_loop_div_regs

`default_nettype wire

// >>> drb_reg_byte.v
// One byte-wide configuration register with reset value and writable mask
`timescale 1ns/10ps
`default_nettype none

module drb_reg_byte #(
   parameter [7:0] RESET_VAL = 8'h00,
   parameter [7:0] WR_MASK = 8'hff
) (
   input wire aclk,
   input wire aresetn,
   input wire wr_en,
   input wire [7:0] wr_data,
   output reg [7:0] value_r
);

   always @(posedge aclk) begin
      if (!aresetn) begin
         value_r <= RESET_VAL;
      end else if (wr_en) begin
         value_r <= wr_data & WR_MASK;
      end
   end

endmodule // drb_reg_byte

`default_nettype wire

// >>> drb_regs_checker.sv
// Assertion checker for the loop divider register slice
`timescale 1ns/10ps
`default_nettype none
module drb_regs_checker (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [15:0] loop_bw_scale_r,
   input wire logic high_margin_filter_r,
   input wire logic [16:0] integer_divider_field_r,
   input wire logic [17:0] feedback_divide_value_r,
   input wire logic [22:0] fraction_numerator_r,
   input wire logic [22:0] fraction_modulus_r
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   sequence s_wr_both;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   a_wr_answer: assert property (s_wr_both |-> ##2 s_axi_bvalid)
      else $error("write response missing");
   a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid)
      else $error("read data missing");
   a_b_clear: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response not cleared");
   a_r_clear: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read data not cleared");
   a_rd_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("upper read lanes not zero");
   a_rresp_legal: assert property (s_axi_rvalid |-> s_axi_rresp inside {2'b00, 2'b10})
      else $error("illegal read response");
   a_bresp_legal: assert property (s_axi_bvalid |-> s_axi_bresp inside {2'b00, 2'b10})
      else $error("illegal write response");
   a_div_plus_one: assert property ($past(aresetn) && $stable(integer_divider_field_r)
      |-> feedback_divide_value_r == integer_divider_field_r + 18'h1)
      else $error("divide value not integer plus one");
   a_reset_vals: assert property ($rose(aresetn) |=> loop_bw_scale_r == 16'h01f4
      && !high_margin_filter_r && integer_divider_field_r == 17'h007cb
      && fraction_numerator_r == 23'h4 && fraction_modulus_r == 23'h5)
      else $error("wrong values after reset");
endmodule // drb_regs_checker

bind drb_loop_div_regs drb_regs_checker u_drb_regs_checker (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .loop_bw_scale_r(loop_bw_scale_r),
   .high_margin_filter_r(high_margin_filter_r),
   .integer_divider_field_r(integer_divider_field_r),
   .feedback_divide_value_r(feedback_divide_value_r),
   .fraction_numerator_r(fraction_numerator_r), .fraction_modulus_r(fraction_modulus_r));
`default_nettype wire

// >>> drb_regs_map.vh
// Register map, field layout and reset values of the loop divider register slice
`ifndef DRB_REGS_MAP_VH
`define DRB_REGS_MAP_VH

// Register indices; printed offsets are not word aligned, byte address = 4 * index
`define DRB_IDX_BW_LO 16'h044e
`define DRB_IDX_BW_HI 16'h044f
`define DRB_IDX_FILT 16'h0450
`define DRB_IDX_INT_LO 16'h0451
`define DRB_IDX_INT_MID 16'h0452
`define DRB_IDX_INT_TOP 16'h0453
`define DRB_IDX_NUM_LO 16'h0454
`define DRB_IDX_NUM_MID 16'h0455
`define DRB_IDX_NUM_HI 16'h0456
`define DRB_IDX_MOD_LO 16'h0457
`define DRB_IDX_MOD_MID 16'h0458
`define DRB_IDX_MOD_HI 16'h0459
`define DRB_IDX_FIRST 16'h044e
`define DRB_NUM_REGS 4'd12

// Reset values
`define DRB_RST_BW_LO 8'hf4
`define DRB_RST_BW_HI 8'h01
`define DRB_RST_FILT 8'h00
`define DRB_RST_INT_LO 8'hcb
`define DRB_RST_INT_MID 8'h07
`define DRB_RST_INT_TOP 8'h00
`define DRB_RST_NUM_LO 8'h04
`define DRB_RST_NUM_MID 8'h00
`define DRB_RST_NUM_HI 8'h00
`define DRB_RST_MOD_LO 8'h05
`define DRB_RST_MOD_MID 8'h00
`define DRB_RST_MOD_HI 8'h00

// Writable bit masks; reserved bits stay zero
`define DRB_MASK_FULL 8'hff
`define DRB_MASK_FILT 8'h02
`define DRB_MASK_INT_TOP 8'h01
`define DRB_MASK_HI7 8'h7f
`define DRB_FILT_BIT 1

// AXI response codes
`define DRB_RESP_OKAY 2'b00
`define DRB_RESP_SLVERR 2'b10

`endif

// >>> tb.sv
// Self-checking bench for the loop divider register slice
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [15:0] awaddr = 16'h0, araddr = 16'h0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, filt;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata, r;
   logic [15:0] bw;
   logic [16:0] intd;
   logic [17:0] fbd;
   logic [22:0] num, modu;
   logic [33:0] exp_r[$];
   logic [1:0] exp_b[$];
   logic [7:0] m[12];
   logic [7:0] dv;
   logic [7:0] rstv[12] = '{8'hf4, 8'h01, 8'h00, 8'hcb, 8'h07, 8'h00, 8'h04, 8'h00, 8'h00,
      8'h05, 8'h00, 8'h00};
   logic [7:0] mk[12] = '{8'hff, 8'hff, 8'h02, 8'hff, 8'hff, 8'h01, 8'hff, 8'hff, 8'h7f,
      8'hff, 8'hff, 8'h7f};
   // Below, above and misaligned against the slice
   logic [15:0] bad[3] = '{16'h1134, 16'h1168, 16'h1139};
   integer seed = 32'h3319;
   int n_fail = 0, samples_checked = 0, i, p;

   initial forever #25 aclk = ~aclk;

   drb_loop_div_regs u_drb_loop_div_regs (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .loop_bw_scale_r(bw), .high_margin_filter_r(filt),
      .integer_divider_field_r(intd), .feedback_divide_value_r(fbd),
      .fraction_numerator_r(num), .fraction_modulus_r(modu));

   // ---------------------------------------
   // Checking and bus tasks
   // ---------------------------------------
   function automatic [15:0] ad(input int k);
      ad = (16'h044e + k[15:0]) << 2;
   endfunction

   task automatic chk(input [33:0] g, input [33:0] e);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic wr(input [15:0] a, input [7:0] d, input [3:0] s, input [1:0] er);
      logic aw_ok, w_ok;
      exp_b.push_back(er);
      r = $random(seed);
      @(posedge aclk);
      awaddr <= a;
      wdata <= {r[31:8], d};
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      while (!(aw_ok && w_ok)) begin
         @(posedge aclk);
         if (awvalid && awready) begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready) begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (!bvalid);
      bready <= 1'b0;
   endtask

   task automatic rd(input [15:0] a, input [7:0] d, input [1:0] er);
      exp_r.push_back({er, 24'h0, d});
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge aclk); while (!rvalid);
      rready <= 1'b0;
   endtask

   task automatic dp_chk();
      chk(bw, {m[1], m[0]});
      chk(filt, m[2][1]);
      chk(intd, {m[5][0], m[4], m[3]});
      chk(fbd, {m[5][0], m[4], m[3]} + 18'h1);
      chk(num, {m[8][6:0], m[7], m[6]});
      chk(modu, {m[11][6:0], m[10], m[9]});
   endtask

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   always @(posedge aclk) begin
      if (rvalid && rready)
         chk({rresp, rdata}, exp_r.pop_front());
      if (bvalid && bready)
         chk(bresp, exp_b.pop_front());
   end

   initial begin
      repeat (30000) @(posedge aclk);
      n_fail++;
      test_done();
   end

   initial begin
      repeat (2) begin
         aresetn <= 1'b0;
         for (i = 0; i < 12; i++) begin
            m[i] = rstv[i];
         end
         repeat (16) @(posedge aclk);
         dp_chk();
         aresetn <= 1'b1;
         repeat (2) @(posedge aclk);
         for (i = 0; i < 12; i++) begin
            rd(ad(i), m[i], 2'b00);
         end
         dp_chk();
         // Random pass, then all ones (0xfe in the numerator low byte) to hit reserved bits and the field tops
         for (p = 0; p < 2; p++) begin
            for (i = 0; i < 12; i++) begin
               r = $random(seed);
               dv = (p == 1) ? 8'hff : r[7:0];
               // Random bandwidth kept between 51.2 Hz and 1.6 kHz
               if (p == 0 && i == 1)
                  dv = {2'b00, r[5:0]} | 8'h02;
               // Modulus kept above the numerator
               if (p == 1 && i == 6)
                  dv = 8'hfe;
               if (p == 0 && i == 8)
                  dv = dv & 8'hbf;
               if (p == 0 && i == 11)
                  dv = dv | 8'h40;
               wr(ad(i), dv, 4'hf, 2'b00);
               m[i] = dv & mk[i];
               rd(ad(i), m[i], 2'b00);
            end
            dp_chk();
         end
         wr(ad(0), ~m[0], 4'he, 2'b00);
         rd(ad(0), m[0], 2'b00);
         for (i = 0; i < 3; i++) begin
            wr(bad[i], 8'h5a, 4'hf, 2'b10);
            rd(bad[i], 8'h00, 2'b10);
         end
         rd(ad(0), m[0], 2'b00);
         dp_chk();
      end
      repeat (2) @(posedge aclk);
      test_done();
   end
endmodule // tb
`default_nettype wire
